// >>> drxos_checker.sv
// Checker of the receive output block ports.
// Assumes bind onto drxos_top; control is shadowed from writes.
`timescale 1ns/1ns
`default_nettype none
`include "drxos_consts.vh"
module drxos_checker (
    // Watched ports
    input wire logic        SYS_CLK,
    input wire logic        ARST_N,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic [9:0]  PARALLEL_CHAR_OUT,
    input wire logic        RECOVERED_CHAR_CLOCK,
    input wire logic        RECOVERED_CHAR_CLOCK_N,
    input wire logic        SELFTEST_STATUS_PIN,
    input wire logic        RECLOCKER_POWERDOWN_FLAG
);
    logic [5:0] ctrl;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    always @(posedge SYS_CLK or negedge ARST_N)
        if (!ARST_N)
            ctrl <= 6'h00;
        else if (WR && ADDR == `DRXOS_ADDR_CTRL)
            ctrl <= WDATA[5:0];
    // Update edge of the character clock
    sequence upd;
        $rose(RECOVERED_CHAR_CLOCK) ||
            ($past(ctrl[0]) && $changed(RECOVERED_CHAR_CLOCK));
    endsequence
    property pdn_p;
        bit v;
        (WR && ADDR == `DRXOS_ADDR_CTRL, v = !(WDATA[3] || WDATA[4]))
            |-> ##2 RECLOCKER_POWERDOWN_FLAG == v;
    endproperty
    clk_pair_a: assert property (
        RECOVERED_CHAR_CLOCK_N != RECOVERED_CHAR_CLOCK)
        else $error("clock pair not complementary");
    data_edge_a: assert property (
        $changed(PARALLEL_CHAR_OUT) |-> upd)
        else $error("data changed off the update edge");
    pin_time_a: assert property (
        $changed(SELFTEST_STATUS_PIN) |-> upd)
        else $error("status pin changed off the update edge");
    pin_gate_a: assert property (
        upd ##0 ($past(ctrl[2:1]) != `DRXOS_BIST_REPORT)
            |-> !SELFTEST_STATUS_PIN)
        else $error("status pin high outside report mode");
    st_data_a: assert property (
        upd ##0 ($past(ctrl[2:1]) != 2'h0)
            |-> PARALLEL_CHAR_OUT[9:2] == 8'h00)
        else $error("upper data bits not zero in self-test");
    pdn_flag_a: assert property (pdn_p)
        else $error("power-down flag wrong after control write");
    clk_run_a: assert property (
        1'b1 |-> ##[1:200] $changed(RECOVERED_CHAR_CLOCK))
        else $error("character clock stopped");
    rd_idle_a: assert property (
        !$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside read answer");
    clr_read_a: assert property (
        $past(RD) && $past(ADDR) == `DRXOS_ADDR_INT_CLR |-> RDATA == 32'h0)
        else $error("clear register read not zero");
endmodule // drxos_checker
bind drxos_top drxos_checker i_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PARALLEL_CHAR_OUT(PARALLEL_CHAR_OUT),
    .RECOVERED_CHAR_CLOCK(RECOVERED_CHAR_CLOCK),
    .RECOVERED_CHAR_CLOCK_N(RECOVERED_CHAR_CLOCK_N),
    .SELFTEST_STATUS_PIN(SELFTEST_STATUS_PIN),
    .RECLOCKER_POWERDOWN_FLAG(RECLOCKER_POWERDOWN_FLAG));
`default_nettype wire

// >>> drxos_clkgen.v
// Recovered character clock generator with enable pulses.
// Assumes a single system clock; divider counts system cycles.
`timescale 1ns/1ns
`default_nettype none

module drxos_clkgen (
    // Clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // Control
    input  wire [7:0] half_period,
    // Outputs
    output reg        clk_level,
    output reg        edge_pulse
);

    reg  [7:0] count;

    // ****************************************************************
    // Free-running divider
    // ****************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count      <= 8'h00;
            clk_level  <= 1'b0;
            edge_pulse <= 1'b0;
        end else if (count + 8'h01 >= half_period) begin
            count      <= 8'h00;
            clk_level  <= ~clk_level;
            edge_pulse <= 1'b1;
        end else begin
            count      <= count + 8'h01;
            edge_pulse <= 1'b0;
        end
    end

endmodule // drxos_clkgen

`default_nettype wire

// >>> drxos_consts.vh
// Constants for the deserializer receive output and status block.
// Assumes inclusion by bare name from design files of this block.
`ifndef DRXOS_CONSTS_VH
`define DRXOS_CONSTS_VH

// ****************************************************************
// Register map (byte offsets)
// ****************************************************************
`define DRXOS_ADDR_CTRL      8'h00
`define DRXOS_ADDR_STATUS    8'h04
`define DRXOS_ADDR_INT_STAT  8'h08
`define DRXOS_ADDR_INT_CLR   8'h0C
`define DRXOS_ADDR_INT_EN    8'h10
`define DRXOS_ADDR_CHAR_IN   8'h14
`define DRXOS_ADDR_TRG_DIV   8'h18

// ****************************************************************
// Control register fields
// ****************************************************************
`define DRXOS_CTRL_RATE      0
`define DRXOS_CTRL_BIST_LO   1
`define DRXOS_CTRL_BIST_HI   2
`define DRXOS_CTRL_ROE1      3
`define DRXOS_CTRL_ROE2      4
`define DRXOS_CTRL_VALID     5
`define DRXOS_CTRL_RESET     6'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define DRXOS_STAT_PDN       0
`define DRXOS_STAT_LOCKREF   1
`define DRXOS_STAT_BIST_LO   2
`define DRXOS_STAT_BIST_HI   4

// ****************************************************************
// Interrupt bits
// ****************************************************************
`define DRXOS_INT_PDN_RISE   0
`define DRXOS_INT_BIST_CHG   1
`define DRXOS_INT_TRG_EDGE   2
`define DRXOS_INT_WIDTH      3

// ****************************************************************
// Values and timing
// ****************************************************************
`define DRXOS_BIST_REPORT    2'h2
`define DRXOS_TRG_DIV_RESET  8'h04
`define DRXOS_BIST_RESET     3'h0

`endif

// >>> drxos_host_model.sv
// Host model capturing parallel characters mid-character.
// Assumes full-rate clocking with a complementary clock pair.
`timescale 1ns/1ns
`default_nettype none
module drxos_host_model (
    // Link from block
    input  wire logic       clk_true,
    input  wire logic       clk_comp,
    input  wire logic [9:0] data,
    input  wire logic       pin,
    // Captured values
    output var  logic [9:0] cap,
    output var  logic [2:0] cap_st
);
    // Capture on falling true clock, away from the update
    always @(posedge clk_comp) begin
        cap    <= data;
        cap_st <= {pin, data[1:0]};
    end
endmodule // drxos_host_model
`default_nettype wire

// >>> drxos_top.v
// One receive channel output stage: parallel characters, self-test
// status, reclocker power-down flag and training clock reference.
// Assumes a 50 MHz system clock and a register port master.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "drxos_consts.vh"

// What this block does
// - Full rate: update data on rising edge
// - Half rate: update on both clock edges
// - Self-test: status on low bits, pin
// - Status pin valid only for control 10
// - Power-down flag when both enables clear
// - Training clock is PLL frequency reference
// - Valid data: clock from software divider
// - Output clock runs continuously at set rate
// - Async reset restores initial state
module drxos_top (
    // System
    input  wire        SYS_CLK,
    input  wire        ARST_N,
    // Register port
    input  wire [7:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    // Training reference clock from pin
    input  wire        CDR_TRAINING_REFERENCE_CLOCK,
    // Self-test status code from checker
    input  wire [2:0]  SELFTEST_CODE,
    // Host-side outputs
    output reg  [9:0]  PARALLEL_CHAR_OUT,
    output reg         RECOVERED_CHAR_CLOCK,
    output reg         RECOVERED_CHAR_CLOCK_N,
    output reg         SELFTEST_STATUS_PIN,
    output reg         RECLOCKER_POWERDOWN_FLAG,
    output reg         IRQ
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg  [5:0]  ctrl;
    reg  [9:0]  char_in;
    reg  [7:0]  trg_div;
    reg  [2:0]  int_stat;
    reg  [2:0]  int_en;
    reg  [2:0]  int_clr;
    reg         trg_s1;
    reg         trg_s2;
    reg         trg_d;
    reg  [2:0]  code_s1;
    reg  [2:0]  code_s2;
    reg  [2:0]  bist_held;
    reg         pdn_d;
    reg  [7:0]  ref_div;
    reg  [7:0]  ref_count;
    reg         ref_edge_seen;
    reg  [9:0]  next_char;
    reg         next_pin;

    wire        rate_half;
    wire [1:0]  bist_ctrl;
    wire        data_valid;
    wire        pdn;
    wire        rec_level;
    wire        rec_edge;
    wire        upd;
    wire        trg_rise;
    wire        bist_on;
    wire [2:0]  events;
    wire [7:0]  half_period;

    assign rate_half  = ctrl[`DRXOS_CTRL_RATE];
    assign bist_ctrl  = ctrl[`DRXOS_CTRL_BIST_HI:`DRXOS_CTRL_BIST_LO];
    assign data_valid = ctrl[`DRXOS_CTRL_VALID];
    assign pdn        = ~ctrl[`DRXOS_CTRL_ROE1] &
                        ~ctrl[`DRXOS_CTRL_ROE2];
    assign bist_on    = bist_ctrl != 2'h0;
    assign trg_rise   = trg_s2 & ~trg_d;

    // Register address match
    function hit;
        input [7:0] a;
        input [7:0] ref_addr;
        begin
            hit = (a == ref_addr);
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            trg_s1  <= 1'b1;
            trg_s2  <= 1'b1;
            trg_d   <= 1'b1;
            code_s1 <= `DRXOS_BIST_RESET;
            code_s2 <= `DRXOS_BIST_RESET;
        end else begin
            trg_s1  <= CDR_TRAINING_REFERENCE_CLOCK;
            trg_s2  <= trg_s1;
            trg_d   <= trg_s2;
            code_s1 <= SELFTEST_CODE;
            code_s2 <= code_s1;
        end
    end

    // ****************************************************************
    // Training reference measurement
    // ****************************************************************
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ref_count     <= 8'h00;
            ref_div       <= `DRXOS_TRG_DIV_RESET;
            ref_edge_seen <= 1'b0;
        end else if (trg_rise) begin
            ref_count     <= 8'h00;
            ref_edge_seen <= 1'b1;
            if (ref_edge_seen && ref_count > 8'h01) begin
                ref_div <= ref_count[7:1] + {7'h00, ref_count[0]};
            end
        end else if (ref_count != 8'hFF) begin
            ref_count <= ref_count + 8'h01;
        end
    end

    // Valid data: software divider; else lock to reference
    assign half_period = data_valid ? trg_div :
                         (rate_half ? {ref_div[6:0], 1'b0} : ref_div);

    // ****************************************************************
    // Recovered clock
    // ****************************************************************
    drxos_clkgen u_clkgen (
        .clk         (SYS_CLK),
        .arst_n      (ARST_N),
        .half_period (half_period),
        .clk_level   (rec_level),
        .edge_pulse  (rec_edge)
    );

    // Full rate: rising edge only; half rate: both edges
    assign upd = rec_edge & (rate_half | rec_level);

    // ****************************************************************
    // Output data and self-test status
    // ****************************************************************
    always @* begin
        next_char = char_in;
        next_pin  = 1'b0;
        if (bist_on) begin
            next_char = {8'h00, bist_held[1:0]};
            if (bist_ctrl == `DRXOS_BIST_REPORT) begin
                next_pin = bist_held[2];
            end
        end
    end

    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PARALLEL_CHAR_OUT      <= 10'h000;
            SELFTEST_STATUS_PIN    <= 1'b0;
            RECOVERED_CHAR_CLOCK   <= 1'b0;
            RECOVERED_CHAR_CLOCK_N <= 1'b1;
            bist_held              <= `DRXOS_BIST_RESET;
        end else begin
            RECOVERED_CHAR_CLOCK   <= rec_level;
            RECOVERED_CHAR_CLOCK_N <= ~rec_level;
            if (upd) begin
                PARALLEL_CHAR_OUT   <= next_char;
                SELFTEST_STATUS_PIN <= next_pin;
                bist_held           <= code_s2;
            end
        end
    end

    // ****************************************************************
    // Power-down flag
    // ****************************************************************
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RECLOCKER_POWERDOWN_FLAG <= 1'b1;
            pdn_d                    <= 1'b1;
        end else begin
            RECLOCKER_POWERDOWN_FLAG <= pdn;
            pdn_d                    <= pdn;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign events[`DRXOS_INT_PDN_RISE] = pdn & ~pdn_d;
    assign events[`DRXOS_INT_BIST_CHG] = upd & bist_on &
                                         (code_s2 != bist_held);
    assign events[`DRXOS_INT_TRG_EDGE] = trg_rise & ~ref_edge_seen;

    always @* begin
        int_clr = 3'h0;
        if (WR && hit(ADDR, `DRXOS_ADDR_INT_CLR)) begin
            int_clr = WDATA[2:0];
        end
    end

    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            int_stat <= 3'h0;
            IRQ      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~int_clr) | events;
            IRQ      <= |(int_stat & int_en);
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl    <= `DRXOS_CTRL_RESET;
            char_in <= 10'h000;
            trg_div <= `DRXOS_TRG_DIV_RESET;
            int_en  <= 3'h0;
        end else if (WR) begin
            if (hit(ADDR, `DRXOS_ADDR_CTRL)) begin
                ctrl <= WDATA[5:0];
            end
            if (hit(ADDR, `DRXOS_ADDR_CHAR_IN)) begin
                char_in <= WDATA[9:0];
            end
            if (hit(ADDR, `DRXOS_ADDR_TRG_DIV)) begin
                trg_div <= (WDATA[7:0] == 8'h00) ? 8'h01 : WDATA[7:0];
            end
            if (hit(ADDR, `DRXOS_ADDR_INT_EN)) begin
                int_en <= WDATA[2:0];
            end
        end
    end

    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 32'h00000000;
        end else if (RD) begin
            case (ADDR)
                `DRXOS_ADDR_CTRL:     RDATA <= {26'h0, ctrl};
                `DRXOS_ADDR_STATUS:   RDATA <= {27'h0, bist_held,
                                                ref_edge_seen, pdn};
                `DRXOS_ADDR_INT_STAT: RDATA <= {29'h0, int_stat};
                `DRXOS_ADDR_INT_EN:   RDATA <= {29'h0, int_en};
                `DRXOS_ADDR_CHAR_IN:  RDATA <= {22'h0, char_in};
                `DRXOS_ADDR_TRG_DIV:  RDATA <= {24'h0, trg_div};
                default:              RDATA <= 32'h00000000;
            endcase
        end else begin
            RDATA <= 32'h00000000;
        end
    end

endmodule // drxos_top

`default_nettype wire

// >>> test_deser_rx_output_status.sv
// Self-checking bench of the receive output block.
// Assumes drxos_top, its bound checker and the host model.
`timescale 1ns/1ns
`default_nettype none
`include "drxos_consts.vh"
module test_deser_rx_output_status;
    logic        clk = 0, arst_n = 0, wr = 0, rd = 0, trg = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [2:0]  code = 3'h0;
    logic [9:0]  ch;
    logic [10:0] ev;
    wire  [31:0] rdata;
    wire  [9:0]  dout, cap;
    wire  [2:0]  cap_st;
    wire         rclk, rclk_n, pin, pdn, irq;
    integer      n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 52997;
    integer      i, j, t;
    time         t0;
    drxos_top i_dut (.SYS_CLK(clk), .ARST_N(arst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CDR_TRAINING_REFERENCE_CLOCK(trg), .SELFTEST_CODE(code),
        .PARALLEL_CHAR_OUT(dout), .RECOVERED_CHAR_CLOCK(rclk),
        .RECOVERED_CHAR_CLOCK_N(rclk_n), .SELFTEST_STATUS_PIN(pin),
        .RECLOCKER_POWERDOWN_FLAG(pdn), .IRQ(irq));
    drxos_host_model i_host (.clk_true(rclk), .clk_comp(rclk_n),
        .data(dout), .pin(pin), .cap(cap), .cap_st(cap_st));
    initial forever #10 clk = ~clk;
    initial begin
        #37;
        forever #80 trg = ~trg;
    end
    // ****
    // Tasks
    // ****
    function automatic logic [10:0] exp_st(input logic [1:0] s,
                                          input logic [2:0] c);
        exp_st = {(s == `DRXOS_BIST_REPORT) & c[2], 8'h00, c[1:0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] m, e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task wait_val(input logic [10:0] e);
        t = 0;
        while ({pin, dout} !== e && t < 100) begin
            @(negedge clk);
            t = t + 1;
        end
        chk({pin, dout}, e);
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (11) @(posedge clk);
        #1 chk({rclk, rclk_n, pin, pdn, irq, dout}, 15'h2800);
        @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(`DRXOS_ADDR_CTRL, 32'hFF, 32'h0);
        rd_reg(`DRXOS_ADDR_TRG_DIV, 32'hFF, `DRXOS_TRG_DIV_RESET);
        rd_reg(8'h1C, 32'hFFFFFFFF, 32'h0);
        rd_reg(`DRXOS_ADDR_INT_CLR, 32'hFFFFFFFF, 32'h0);
        repeat (10) @(posedge clk);
        rd_reg(`DRXOS_ADDR_STATUS, 32'h2, 32'h2);
        wr_reg(`DRXOS_ADDR_INT_EN, 32'h7);
        wr_reg(`DRXOS_ADDR_INT_CLR, 32'h7);
        wr_reg(`DRXOS_ADDR_CTRL, 32'h08);
        rd_reg(`DRXOS_ADDR_STATUS, 32'h1, 32'h0);
        wr_reg(`DRXOS_ADDR_CTRL, 32'h00);
        rd_reg(`DRXOS_ADDR_INT_STAT, 32'h1, 32'h1);
        chk(irq, 1'b1);
        wr_reg(`DRXOS_ADDR_INT_CLR, 32'h1);
        rd_reg(`DRXOS_ADDR_INT_STAT, 32'h1, 32'h0);
        chk(irq, 1'b0);
        wr_reg(`DRXOS_ADDR_INT_EN, 32'h0);
        wr_reg(`DRXOS_ADDR_CTRL, 32'h10);
        wr_reg(`DRXOS_ADDR_CTRL, 32'h00);
        rd_reg(`DRXOS_ADDR_INT_STAT, 32'h1, 32'h1);
        chk(irq, 1'b0);
        wr_reg(`DRXOS_ADDR_INT_EN, 32'h1);
        rd_reg(`DRXOS_ADDR_INT_EN, 32'h7, 32'h1);
        chk(irq, 1'b1);
        wr_reg(`DRXOS_ADDR_INT_CLR, 32'h7);
        wr_reg(`DRXOS_ADDR_TRG_DIV, 32'h6);
        wr_reg(`DRXOS_ADDR_CTRL, 32'h20);
        @(rclk);
        @(rclk);
        t0 = $time;
        @(rclk);
        chk(32'($time - t0), 32'd120);
        wr_reg(`DRXOS_ADDR_TRG_DIV, 32'h3);
        for (i = 0; i < 2; i = i + 1) begin
            wr_reg(`DRXOS_ADDR_CTRL, 32'h20 | i);
            for (j = 0; j < 6; j = j + 1) begin
                ch = (j == 0) ? 10'h3FF :
                     (j == 1) ? 10'h000 : 10'($random(seed));
                wr_reg(`DRXOS_ADDR_CHAR_IN, {22'h0, ch});
                wait_val({1'b0, ch});
                if (i == 0) begin
                    @(posedge rclk_n);
                    #1 chk(cap, ch);
                end
            end
        end
        for (i = 1; i < 4; i = i + 1) begin
            wr_reg(`DRXOS_ADDR_CTRL, 32'h20 | (i << 1));
            code <= 3'($random(seed));
            repeat (16) @(negedge clk);
            ev = exp_st(2'(i), code);
            wait_val(ev);
            rd_reg(`DRXOS_ADDR_STATUS, 32'h1C, {27'h0, code, 2'h0});
            @(posedge rclk_n);
            #1 chk(cap_st, {ev[10], ev[1:0]});
        end
        final_report;
    end
endmodule // test_deser_rx_output_status
`default_nettype wire
